// ===== src/mph_pkg.sv
package mph_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned STYLE_W = 3;
  localparam logic [2:0] STYLE_SPLIT = 3'h0;
  localparam logic [2:0] STYLE_DIR = 3'h1;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LAT_MIN = 4;
  localparam int unsigned LAT_WR_MAX = 9;
  localparam int unsigned LAT_RD_MAX = 13;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned REG_COUNT = 8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int unsigned HOST_TIMEOUT = 31;
  typedef enum logic [3:0] {
    MPH_IDLE = 4'h1,
    MPH_WAIT = 4'h2,
    MPH_ACK = 4'h4,
    MPH_DONE = 4'h8
  } mph_state_type;
endpackage

// ===== src/mph_if.sv
interface mph_if;
  logic [2:0] style_sel;
  logic cs_n;
  logic [2:0] addr;
  logic strobe_n;
  logic dir;
  logic [7:0] data_host;
  logic data_host_oe;
  logic [7:0] data_dev;
  logic data_dev_oe;
  logic ack_o;
  logic ack_oe;
  modport device (input style_sel, cs_n, addr, strobe_n, dir, data_host,
    data_host_oe, output data_dev, data_dev_oe, ack_o, ack_oe);
  modport host (output style_sel, cs_n, addr, strobe_n, dir, data_host,
    data_host_oe, input data_dev, data_dev_oe, ack_o, ack_oe);
endinterface

// ===== src/mph_device.sv
module mph_device (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Async reset
  mph_if.device port, // Microport pins
  output logic [63:0] cfg_regs // Configuration contents
);
  logic [7:0] mem_q [mph_pkg::REG_COUNT];
  mph_pkg::mph_state_type state_q;
  logic [3:0] cnt_q;
  logic [3:0] target_q;
  logic rd_q;
  logic [2:0] addr_q;
  logic [7:0] rdata_q;
  logic ack_q;
  logic split;
  logic req;
  logic is_rd;
  logic strobe_on;
  logic strobe_q;
  logic start;
  logic fire;
  logic [3:0] rd_lat;
  logic [3:0] wr_lat;

  // --------------------------------------------------
  // Pin decode
  // --------------------------------------------------
  assign split = port.style_sel == mph_pkg::STYLE_SPLIT;
  assign strobe_on = split ? (!port.strobe_n || !port.dir) : !port.strobe_n;
  assign is_rd = split ? !port.strobe_n : port.dir;
  assign req = strobe_on && !port.cs_n;

  // --------------------------------------------------
  // Strobe edge
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe_on;
    end
  end

  // Access begins on strobe assertion only
  assign start = req && !strobe_q;
  assign fire = state_q == mph_pkg::MPH_WAIT && strobe_on &&
                cnt_q + 4'h1 >= target_q;

  // --------------------------------------------------
  // Latency by address
  // --------------------------------------------------
  always_comb begin
    unique case (port.addr)
      3'h0: begin
        rd_lat = 4'(mph_pkg::LAT_MIN);
        wr_lat = 4'(mph_pkg::LAT_MIN);
      end
      3'h1: begin
        rd_lat = 4'(mph_pkg::LAT_MIN + 1);
        wr_lat = 4'(mph_pkg::LAT_MIN);
      end
      3'h2: begin
        rd_lat = 4'(mph_pkg::LAT_MIN + 2);
        wr_lat = 4'(mph_pkg::LAT_MIN + 1);
      end
      3'h3: begin
        rd_lat = 4'(mph_pkg::LAT_MIN + 3);
        wr_lat = 4'(mph_pkg::LAT_MIN + 1);
      end
      3'h4: begin
        rd_lat = 4'(mph_pkg::LAT_MIN + 4);
        wr_lat = 4'(mph_pkg::LAT_MIN + 2);
      end
      3'h5: begin
        rd_lat = 4'(mph_pkg::LAT_MIN + 5);
        wr_lat = 4'(mph_pkg::LAT_MIN + 2);
      end
      3'h6: begin
        rd_lat = 4'(mph_pkg::LAT_MIN + 6);
        wr_lat = 4'(mph_pkg::LAT_MIN + 3);
      end
      3'h7: begin
        rd_lat = 4'(mph_pkg::LAT_MIN + 7);
        wr_lat = 4'(mph_pkg::LAT_MIN + 3);
      end
    endcase
  end

  // --------------------------------------------------
  // Handshake sequencer
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= mph_pkg::MPH_IDLE;
    end else begin
      unique case (state_q)
        mph_pkg::MPH_IDLE: begin
          if (start) begin
            state_q <= mph_pkg::MPH_WAIT;
          end
        end
        mph_pkg::MPH_WAIT: begin
          if (!strobe_on) begin
            state_q <= mph_pkg::MPH_IDLE;
          end else if (cnt_q + 4'h1 >= target_q) begin
            state_q <= mph_pkg::MPH_ACK;
          end
        end
        mph_pkg::MPH_ACK: begin
          if (!strobe_on) begin
            state_q <= mph_pkg::MPH_IDLE;
          end
        end
        default: begin
          state_q <= mph_pkg::MPH_IDLE;
        end
      endcase
    end
  end

  // Counts strobe cycles toward the target
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else if (state_q == mph_pkg::MPH_IDLE && start) begin
      cnt_q <= 4'h1;
    end else if (state_q == mph_pkg::MPH_WAIT && strobe_on && !fire) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // --------------------------------------------------
  // Access capture
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_q <= 1'b0;
    end else if (state_q == mph_pkg::MPH_IDLE && start) begin
      rd_q <= is_rd;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_q <= 3'h0;
    end else if (state_q == mph_pkg::MPH_IDLE && start) begin
      addr_q <= port.addr;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      target_q <= 4'h0;
    end else if (state_q == mph_pkg::MPH_IDLE && start) begin
      target_q <= is_rd ? rd_lat : wr_lat;
    end
  end

  // --------------------------------------------------
  // Register file
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < mph_pkg::REG_COUNT; i++) begin
        mem_q[i] <= mph_pkg::REG_RESET;
      end
    end else if (fire && !rd_q) begin
      mem_q[addr_q] <= port.data_host;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (fire && rd_q) begin
      rdata_q <= mem_q[addr_q];
    end
  end

  // --------------------------------------------------
  // Acknowledge
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= fire || (state_q == mph_pkg::MPH_ACK && strobe_on);
    end
  end

  always_comb begin
    for (int i = 0; i < mph_pkg::REG_COUNT; i++) begin
      cfg_regs[i*8 +: 8] = mem_q[i];
    end
  end

  // --------------------------------------------------
  // Pin drive
  // --------------------------------------------------
  assign port.data_dev = rdata_q;
  assign port.data_dev_oe = ack_q && rd_q && !port.cs_n;
  assign port.ack_o = 1'b0;
  // Split: hold low until ready; direction: pull low on ack
  assign port.ack_oe = split ? (req && !ack_q) : ack_q;
endmodule

// ===== src/mph_host.sv
module mph_host (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic [2:0] style, // Handshake style
  input wire logic req_valid, // Request
  input wire logic req_write, // 1 write, 0 read
  input wire logic [2:0] req_addr, // Address
  input wire logic [7:0] req_wdata, // Write data
  output logic req_ready, // Idle, may accept
  output logic done, // Completion pulse
  output logic timeout, // No acknowledge pulse
  output logic [7:0] rdata, // Read data
  mph_if.host port // Microport pins
);
  mph_pkg::mph_state_type state_q;
  logic write_q;
  logic [2:0] addr_q;
  logic [7:0] wdata_q;
  logic [4:0] tmo_q;
  logic ack_seen;

  // Wired level: pulled up unless device sinks
  assign ack_seen = port.ack_oe ? port.ack_o : 1'b1;
  assign port.style_sel = style;
  assign req_ready = state_q == mph_pkg::MPH_IDLE;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= mph_pkg::MPH_IDLE;
      write_q <= 1'b0;
      addr_q <= 3'h0;
      wdata_q <= 8'h00;
      tmo_q <= 5'h00;
      done <= 1'b0;
      timeout <= 1'b0;
      rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      timeout <= 1'b0;
      unique case (state_q)
        mph_pkg::MPH_IDLE: begin
          if (req_valid) begin
            state_q <= mph_pkg::MPH_WAIT;
            write_q <= req_write;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
          end
        end
        mph_pkg::MPH_WAIT: begin
          state_q <= mph_pkg::MPH_ACK;
          tmo_q <= 5'h00;
        end
        mph_pkg::MPH_ACK: begin
          tmo_q <= tmo_q + 5'h01;
          if ((style == mph_pkg::STYLE_SPLIT) ? ack_seen : !ack_seen) begin
            state_q <= mph_pkg::MPH_DONE;
            done <= 1'b1;
            rdata <= port.data_dev;
          end else if (tmo_q == 5'(mph_pkg::HOST_TIMEOUT)) begin
            state_q <= mph_pkg::MPH_DONE;
            timeout <= 1'b1;
          end
        end
        mph_pkg::MPH_DONE: begin
          state_q <= mph_pkg::MPH_IDLE;
        end
        default: begin
          state_q <= mph_pkg::MPH_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------
  // Pin drive
  // --------------------------------------------------
  logic active;
  assign active = state_q == mph_pkg::MPH_ACK;
  assign port.cs_n = !(state_q == mph_pkg::MPH_WAIT || active);
  assign port.addr = addr_q;
  assign port.strobe_n = (style == mph_pkg::STYLE_SPLIT) ?
                         !(active && !write_q) : !active;
  assign port.dir = (style == mph_pkg::STYLE_SPLIT) ?
                    !(active && write_q) : !write_q;
  assign port.data_host = wdata_q;
  assign port.data_host_oe = write_q && !port.cs_n;
endmodule

// ===== verification/mph_assertions.sv
module mph_assertions (
  input logic sys_clk, // Clock
  input logic rst, // Async reset
  input logic [2:0] style_sel, // Style
  input logic cs_n, // Chip select
  input logic strobe_n, // Shared or read strobe
  input logic dir, // Direction or write strobe
  input logic data_dev_oe, // Device read drive
  input logic ack_o, // Ack level
  input logic ack_oe // Ack sink
);
  timeunit 1ns;
  timeprecision 1ps;
  logic split, strb, act, rd, ackd;
  logic [3:0] cnt_q;
  assign split = style_sel == mph_pkg::STYLE_SPLIT;
  assign strb = split ? (!strobe_n || !dir) : !strobe_n;
  assign act = !cs_n && strb;
  assign rd = split ? !strobe_n : dir;
  assign ackd = split ? !ack_oe : ack_oe;
  // ----
  // Cycles since strobe
  // ----
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= act ? cnt_q + {3'h0, cnt_q != 4'hf} : 4'h0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_end;
    $fell(act);
  endsequence
  a_early_ack: assert property (
    act && cnt_q inside {[4'h1:4'h3]} |-> !ackd) else $error("early ack");
  a_write_bound: assert property (
    act && !rd && !ackd |-> cnt_q < 4'ha) else $error("slow write");
  a_read_bound: assert property (
    act && rd && !ackd |-> cnt_q < 4'he) else $error("slow read");
  a_ack_release: assert property (
    s_end |-> ##[0:2] !ack_oe) else $error("ack held");
  a_open_drain: assert property (
    ack_oe |-> ack_o == 1'b0) else $error("ack driven high");
  a_dev_drive: assert property (
    data_dev_oe |-> $past(act && rd)) else $error("stray data drive");
  a_read_data: assert property (
    act && rd && ackd && cnt_q > 4'h3 |-> data_dev_oe)
    else $error("ack without data");
  a_cs_qualify: assert property (
    strb |-> !cs_n) else $error("strobe without select");
  a_style_stable: assert property (
    act |-> $stable(style_sel)) else $error("style changed");
endmodule

// ===== verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] style = 3'h0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [2:0] req_addr = 3'h0;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, done, timeout;
  logic [7:0] rdata;
  logic [63:0] cfg_regs;
  logic [2:0] styles [3] = '{3'h0, 3'h1, 3'h5};
  int fail_count = 0;
  int num_checks = 0;
  mph_if u_mph_if ();
  mph_device u_mph_device (.sys_clk(sys_clk), .rst(rst),
    .port(u_mph_if.device), .cfg_regs(cfg_regs));
  mph_host u_mph_host (.sys_clk(sys_clk), .rst(rst), .style(style),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .done(done),
    .timeout(timeout), .rdata(rdata), .port(u_mph_if.host));
  mph_assertions u_mph_assertions (.sys_clk(sys_clk), .rst(rst),
    .style_sel(u_mph_if.style_sel), .cs_n(u_mph_if.cs_n),
    .strobe_n(u_mph_if.strobe_n), .dir(u_mph_if.dir),
    .data_dev_oe(u_mph_if.data_dev_oe), .ack_o(u_mph_if.ack_o),
    .ack_oe(u_mph_if.ack_oe));
  always #5 sys_clk = ~sys_clk;
  // ----
  // Tasks
  // ----
  function automatic logic [7:0] dat(input int s, input int a);
    return 8'h5a ^ {a[2:0], s[1:0], a[2:0]};
  endfunction
  task automatic check(input string what, input logic [63:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic access(input logic w, input logic [2:0] a,
    input logic [7:0] d, output int lat);
    lat = 0;
    while (req_ready !== 1'b1) @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    while (done !== 1'b1 && lat < 40) begin
      @(posedge sys_clk);
      lat++;
    end
    check("completion", {timeout, lat < 40}, 2'b01);
  endtask
  // ----
  // Tests
  // ----
  initial begin
    int l0;
    int lat;
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk);
      rst <= 1'b1;
      style <= styles[s];
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      check("reset regs", cfg_regs, 64'h0);
      for (int a = 0; a < 8; a++) begin
        access(1'b1, a[2:0], dat(s, a), lat);
        if (a == 0) l0 = lat;
      end
      check("write spread", 64'(lat - l0), 64'h3);
      for (int a = 0; a < 8; a++) begin
        check("reg", 64'(cfg_regs[a*8 +: 8]), 64'(dat(s, a)));
      end
      for (int a = 0; a < 8; a++) begin
        access(1'b0, a[2:0], 8'h00, lat);
        if (a == 0) l0 = lat;
        check("rdata", 64'(rdata), 64'(dat(s, a)));
      end
      check("read spread", 64'(lat - l0), 64'h7);
    end
    summarize();
  end
  initial begin
    #50000;
    fail_count++;
    summarize();
  end
endmodule
